/* common/ppid_regs.svh */
// constants and timing counts for the position loop block
// ============================================================
// Summary of operation
// RULE1: flag encoder fault when no encoder motion while applied power at least quarter scale.
// RULE2: after encoder fault stop driving motors, stay halted until reset.
// RULE3: while encoder fault holds, flash diagnostic indicator rapidly.
// RULE4: each control period sample position, error is desired minus actual.
// RULE5: proportional term is error times configurable proportional gain.
// RULE6: differential term is error change since last period times differential gain.
// RULE7: integral term is running error sum times integral gain.
// RULE8: zero integral gain in steady state gives power equal error times proportional gain; code gives error times kp shifted right by PPID_GAIN_SHIFT (3).
// RULE9: command equal to position with no integral gives zero power.
// RULE10: one shared gain set serves both motor channels.
// RULE11: emergency stop input shuts down motor outputs.
// RULE12: stay inactive while emergency stop held, resume after release.
// RULE13: emergency stop disables both channels together.
// RULE14: commander must not target positions outside sensor reachable range.
// RULE15: configurer keeps current limit at most twice normal load current.
// RULE16: drive motor towards target while position differs, until reached.
// RULE17: feedback from analog inputs 1 and 2, or 3 and 4 in analog command mode.
// RULE18: saturate summed output to full scale power each direction.
// RULE19: judge no-motion over configurable number of control periods before fault.
`ifndef PPID_REGS_SVH
`define PPID_REGS_SVH
// ============================================================
// timing
`define PPID_CLK_HZ 50000000
`define PPID_PERIOD_MS 16
`define PPID_PERIOD_CYC ((`PPID_CLK_HZ / 1000) * `PPID_PERIOD_MS)
`define PPID_FLASH_MS 100
`define PPID_FLASH_CYC ((`PPID_CLK_HZ / 1000) * `PPID_FLASH_MS)
// ============================================================
// scaling
`define PPID_PWR_MAX 16'sd127
`define PPID_PWR_MIN -16'sd127
`define PPID_QUARTER 8'd32
`define PPID_NOMOVE_PERIODS 8'd8
`define PPID_GAIN_SHIFT 3
`endif

/* common/ppid_pkg.sv */
// types for the position loop block
package ppid_pkg;
  typedef logic signed [7:0] ppid_pos_t;
  typedef logic [7:0] ppid_gain_t;
  // shared gain set for both channels
  typedef struct packed {
    ppid_gain_t kp;
    ppid_gain_t ki;
    ppid_gain_t kd;
  } ppid_gains_s;
  typedef enum logic [1:0] {
    PPID_RUN = 2'b00,
    PPID_ESTOP = 2'b01,
    PPID_FAULT = 2'b10
  } ppid_state_e;
endpackage

/* rtl/ppid_chan.sv */
// one channel of position pid arithmetic
`timescale 1ns/100ps
`default_nettype none
`include "ppid_regs.svh"
module ppid_chan (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire ppid_pkg::ppid_pos_t target,
  input wire ppid_pkg::ppid_pos_t actual,
  input wire ppid_pkg::ppid_gains_s gains,
  output logic signed [7:0] power
);
  logic signed [8:0] err_ff, nxt_err;
  logic signed [19:0] isum_ff, nxt_isum;
  logic signed [7:0] pwr_ff, nxt_pwr;
  logic signed [8:0] err_now;
  logic signed [31:0] sum;

  // ============================================================
  // pid step; integral clamped so it cannot wind up without bound
  always_comb begin
    err_now = 9'(target) - 9'(actual); // see RULE4
    nxt_err = err_ff;
    nxt_isum = isum_ff;
    nxt_pwr = pwr_ff;
    sum = 32'sd0;
    if (!run) begin
      nxt_pwr = 8'sd0;
      nxt_isum = 20'sd0;
      nxt_err = 9'sd0;
    end else if (tick) begin
      nxt_isum = isum_ff + 20'(err_now); // see RULE7
      if (nxt_isum > 20'sd32000) nxt_isum = 20'sd32000;
      if (nxt_isum < -20'sd32000) nxt_isum = -20'sd32000;
      sum = 32'(err_now) * $signed({1'b0, gains.kp}) // see RULE5
        + (32'(err_now) - 32'(err_ff)) * $signed({1'b0, gains.kd}) // see RULE6
        + 32'(isum_ff) * $signed({1'b0, gains.ki}); // see RULE7
      sum = sum >>> `PPID_GAIN_SHIFT;
      // see RULE18
      if (sum > 32'(`PPID_PWR_MAX)) nxt_pwr = 8'(`PPID_PWR_MAX);
      else if (sum < 32'(`PPID_PWR_MIN)) nxt_pwr = 8'(`PPID_PWR_MIN);
      else nxt_pwr = 8'(sum); // see RULE8 RULE9 RULE16
      nxt_err = err_now;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_ff <= 9'sd0;
      isum_ff <= 20'sd0;
      pwr_ff <= 8'sd0;
    end else begin
      err_ff <= nxt_err;
      isum_ff <= nxt_isum;
      pwr_ff <= nxt_pwr;
    end
  end
  assign power = pwr_ff;
endmodule // ppid_chan
`default_nettype wire

/* rtl/ppid_top.sv */
// position pid loop, two channels, with encoder fault halt and emergency stop
`timescale 1ns/100ps
`default_nettype none
`include "ppid_regs.svh"
module ppid_top #(
  parameter int PERIOD_CYC = `PPID_PERIOD_CYC,
  parameter int FLASH_CYC = `PPID_FLASH_CYC,
  parameter logic [7:0] NOMOVE_PERIODS = `PPID_NOMOVE_PERIODS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ppid_pkg::ppid_pos_t target1,
  input wire ppid_pkg::ppid_pos_t target2,
  input wire ppid_pkg::ppid_pos_t ana1,
  input wire ppid_pkg::ppid_pos_t ana2,
  input wire ppid_pkg::ppid_pos_t ana3,
  input wire ppid_pkg::ppid_pos_t ana4,
  input wire logic analog_cmd_mode,
  input wire ppid_pkg::ppid_gains_s gains,
  input wire logic encoder_en,
  input wire logic enc1_step,
  input wire logic enc2_step,
  input wire logic estop,
  output logic signed [7:0] power1,
  output logic signed [7:0] power2,
  output logic motors_on,
  output logic enc_fault,
  output logic diag_led
);
  // ============================================================
  // pin synchronisers; first stage feeds only the second
  logic [3:0] s1_ff, s2_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
    end else begin
      s1_ff <= {estop, enc1_step, enc2_step, encoder_en};
      s2_ff <= s1_ff;
    end
  end
  logic estop_s, enc1_s, enc2_s, encen_s;
  assign {estop_s, enc1_s, enc2_s, encen_s} = s2_ff;

  // ============================================================
  // 16 ms period tick divider
  logic [31:0] div_ff, nxt_div;
  logic tick;
  always_comb begin
    tick = (div_ff == 32'(PERIOD_CYC - 1));
    nxt_div = tick ? 32'h0 : div_ff + 32'h1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) div_ff <= 32'h0;
    else div_ff <= nxt_div;
  end

  // ============================================================
  // feedback select and sample each period
  ppid_pkg::ppid_pos_t fb1_ff, fb2_ff, nxt_fb1, nxt_fb2;
  always_comb begin
    nxt_fb1 = fb1_ff;
    nxt_fb2 = fb2_ff;
    if (tick) begin
      nxt_fb1 = analog_cmd_mode ? ana3 : ana1; // see RULE17 RULE4
      nxt_fb2 = analog_cmd_mode ? ana4 : ana2; // see RULE17
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fb1_ff <= 8'sd0;
      fb2_ff <= 8'sd0;
    end else begin
      fb1_ff <= nxt_fb1;
      fb2_ff <= nxt_fb2;
    end
  end
  // pid runs one cycle after the sample so it sees the fresh position
  logic tick_d_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) tick_d_ff <= 1'b0;
    else tick_d_ff <= tick;
  end

  // ============================================================
  // run state: fault is sticky until reset, estop holds while asserted
  ppid_pkg::ppid_state_e st_ff, nxt_st;
  logic run;
  logic fault_hit;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ppid_pkg::PPID_RUN: begin
        if (fault_hit) nxt_st = ppid_pkg::PPID_FAULT; // see RULE2
        else if (estop_s) nxt_st = ppid_pkg::PPID_ESTOP; // see RULE11
      end
      ppid_pkg::PPID_ESTOP: begin
        if (!estop_s) nxt_st = ppid_pkg::PPID_RUN; // see RULE12
      end
      ppid_pkg::PPID_FAULT: nxt_st = ppid_pkg::PPID_FAULT; // see RULE2
      default: nxt_st = ppid_pkg::PPID_FAULT;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) st_ff <= ppid_pkg::PPID_RUN;
    else st_ff <= nxt_st;
  end
  // estop seen combinationally too, so outputs drop the same edge
  assign run = (st_ff == ppid_pkg::PPID_RUN) && !estop_s; // see RULE13

  // ============================================================
  // shared gains feed both channels
  logic signed [7:0] p1, p2;
  ppid_chan u_ch1 (
    .core_clk(core_clk), .rst_n(rst_n), .tick(tick_d_ff), .run(run),
    .target(target1), .actual(fb1_ff), .gains(gains), .power(p1) // see RULE10
  );
  ppid_chan u_ch2 (
    .core_clk(core_clk), .rst_n(rst_n), .tick(tick_d_ff), .run(run),
    .target(target2), .actual(fb2_ff), .gains(gains), .power(p2) // see RULE10
  );
  // gate outputs with run so a fault or estop kills power at once
  assign power1 = run ? p1 : 8'sd0; // see RULE13
  assign power2 = run ? p2 : 8'sd0; // see RULE13
  assign motors_on = run;

  // ============================================================
  // encoder no-motion watch over several periods
  logic [7:0] nm_ff, nxt_nm;
  logic mov_ff, nxt_mov;
  logic e1_d_ff, e2_d_ff;
  logic big_pwr;
  function automatic logic mag_ge(input logic signed [7:0] v);
    mag_ge = (v >= $signed({1'b0, `PPID_QUARTER - 8'd0}) ) || (v <= -$signed({1'b0, `PPID_QUARTER}));
  endfunction
  assign big_pwr = mag_ge(p1) || mag_ge(p2); // see RULE1
  always_comb begin
    nxt_mov = mov_ff || (enc1_s != e1_d_ff) || (enc2_s != e2_d_ff);
    nxt_nm = nm_ff;
    fault_hit = 1'b0;
    if (tick) begin
      // motion seen on the tick cycle opens the next window, so it is not lost
      nxt_mov = (enc1_s != e1_d_ff) || (enc2_s != e2_d_ff);
      if (encen_s && run && big_pwr && !mov_ff) nxt_nm = nm_ff + 8'd1; // see RULE1
      else nxt_nm = 8'd0;
      if (encen_s && run && big_pwr && !mov_ff && (nm_ff + 8'd1 >= NOMOVE_PERIODS)) fault_hit = 1'b1; // see RULE19
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nm_ff <= 8'd0;
      mov_ff <= 1'b0;
      e1_d_ff <= 1'b0;
      e2_d_ff <= 1'b0;
    end else begin
      nm_ff <= nxt_nm;
      mov_ff <= nxt_mov;
      e1_d_ff <= enc1_s;
      e2_d_ff <= enc2_s;
    end
  end
  assign enc_fault = (st_ff == ppid_pkg::PPID_FAULT);

  // ============================================================
  // rapid flash of the diagnostic indicator while faulted
  logic [31:0] fl_ff, nxt_fl;
  logic led_ff, nxt_led;
  always_comb begin
    nxt_fl = fl_ff + 32'h1;
    nxt_led = led_ff;
    if (!enc_fault) begin
      nxt_fl = 32'h0;
      nxt_led = 1'b0;
    end else if (fl_ff >= 32'(FLASH_CYC - 1)) begin
      nxt_fl = 32'h0;
      nxt_led = !led_ff; // see RULE3
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fl_ff <= 32'h0;
      led_ff <= 1'b0;
    end else begin
      fl_ff <= nxt_fl;
      led_ff <= nxt_led;
    end
  end
  assign diag_led = led_ff;

  // ============================================================
  // checks
  property p_fault_sticky;
    @(posedge core_clk) disable iff (!rst_n) enc_fault |=> enc_fault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared without reset"); // see RULE2
  property p_fault_nopower;
    @(posedge core_clk) disable iff (!rst_n) enc_fault |-> (power1 == 8'sd0 && power2 == 8'sd0);
  endproperty
  a_fault_nopower: assert property (p_fault_nopower) else $error("power while faulted"); // see RULE2
  property p_estop_off;
    @(posedge core_clk) disable iff (!rst_n) estop_s |-> (power1 == 8'sd0 && power2 == 8'sd0 && !motors_on);
  endproperty
  a_estop_off: assert property (p_estop_off) else $error("power during estop"); // see RULE11
  property p_estop_both;
    @(posedge core_clk) disable iff (!rst_n) !motors_on |-> (power1 == 8'sd0) && (power2 == 8'sd0);
  endproperty
  a_estop_both: assert property (p_estop_both) else $error("one channel left on"); // see RULE13
  property p_estop_resume;
    @(posedge core_clk) disable iff (!rst_n) $fell(estop_s) && !enc_fault |=> motors_on;
  endproperty
  a_estop_resume: assert property (p_estop_resume) else $error("no resume after estop"); // see RULE12
  property p_fault_cause;
    @(posedge core_clk) disable iff (!rst_n) $rose(enc_fault) |-> $past(big_pwr) && $past(encen_s);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without high power"); // see RULE1
  property p_led_flash;
    @(posedge core_clk) disable iff (!rst_n) !enc_fault |-> !diag_led;
  endproperty
  a_led_flash: assert property (p_led_flash) else $error("led on without fault"); // see RULE3
  property p_sat;
    @(posedge core_clk) disable iff (!rst_n) (power1 >= -8'sd127) && (power2 >= -8'sd127);
  endproperty
  a_sat: assert property (p_sat) else $error("power beyond full scale"); // see RULE18
  property p_count;
    @(posedge core_clk) disable iff (!rst_n) $rose(enc_fault) |-> $past(nm_ff) + 8'd1 >= NOMOVE_PERIODS;
  endproperty
  a_count: assert property (p_count) else $error("fault before period count"); // see RULE19
  c_fault: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(enc_fault));
  c_estop: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(estop_s));
  c_drive: cover property (@(posedge core_clk) disable iff (!rst_n) power1 == 8'sd127);
endmodule // ppid_top
`default_nettype wire

/* test/ppid_plant.sv */
// plant model: shaft encoders pulse while power is applied
`timescale 1ns/100ps
`default_nettype none
module ppid_plant (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic signed [7:0] power1,
  input wire logic signed [7:0] power2,
  output logic enc1_step,
  output logic enc2_step
);
  // supply is current limited to twice the normal load draw
  localparam int NORM_DRAW = 32;
  localparam int CUR_LIM = 2 * NORM_DRAW;
  logic t1_ff = 1'b0;
  logic t2_ff = 1'b0;
  int draw1, draw2;
  always_comb begin
    draw1 = (power1 < 8'sh00) ? -int'(power1) : int'(power1);
    draw2 = (power2 < 8'sh00) ? -int'(power2) : int'(power2);
    if (draw1 > CUR_LIM) draw1 = CUR_LIM;
    if (draw2 > CUR_LIM) draw2 = CUR_LIM;
  end
  // a stalled shaft gives no edges at all, as a broken encoder would
  always @(posedge core_clk) begin
    if (!stall && draw1 > 0) t1_ff <= ~t1_ff;
    if (!stall && draw2 > 0) t2_ff <= ~t2_ff;
  end
  assign enc1_step = t1_ff;
  assign enc2_step = t2_ff;
endmodule // ppid_plant
`default_nettype wire

/* test/ppid_top_tb_top.sv */
// self-checking bench for the two-channel position loop
`timescale 1ns/100ps
`default_nettype none
`include "ppid_regs.svh"
module ppid_top_tb_top;
  localparam int PER = 20;
  localparam int FL = 4;
  localparam int NM = 2;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ppid_pkg::ppid_pos_t target1, target2, ana1, ana2, ana3, ana4;
  ppid_pkg::ppid_gains_s gains;
  logic stall, analog_cmd_mode, encoder_en, estop, enc1_step, enc2_step;
  logic motors_on, enc_fault, diag_led, old;
  logic signed [7:0] power1, power2, p;
  int bad_count = 0;
  int tests_run = 0;
  int e, k;
  logic [31:0] seed = 32'h27;
  logic [31:0] r;
  // ============================================================
  // clock, design and plant
  always #10 core_clk = ~core_clk;
  ppid_top #(.PERIOD_CYC(PER), .FLASH_CYC(FL), .NOMOVE_PERIODS(8'h02)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .target1(target1), .target2(target2),
    .ana1(ana1), .ana2(ana2), .ana3(ana3), .ana4(ana4), .analog_cmd_mode(analog_cmd_mode),
    .gains(gains), .encoder_en(encoder_en), .enc1_step(enc1_step), .enc2_step(enc2_step),
    .estop(estop), .power1(power1), .power2(power2), .motors_on(motors_on),
    .enc_fault(enc_fault), .diag_led(diag_led));
  ppid_plant plant_u (.core_clk(core_clk), .stall(stall), .power1(power1), .power2(power2),
    .enc1_step(enc1_step), .enc2_step(enc2_step));
  // ============================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // saturated p plus d output, integral left out
  function automatic logic signed [7:0] pexp(int e, int de, int kp, int kd);
    int v;
    v = (e * kp + de * kd) >>> `PPID_GAIN_SHIFT;
    if (v > 127) v = 127;
    if (v < -127) v = -127;
    return v[7:0];
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait for the next power update on channel one
  task automatic wait_p1(logic [7:0] prev);
    for (int i = 0; i < 4 * PER && power1 === prev; i++) cyc(1);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog sized well beyond the whole sequence
  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
  // ============================================================
  // main sequence
  initial begin
    {target1, target2, ana1, ana2, ana3, ana4} = '0;
    {stall, analog_cmd_mode, encoder_en, estop} = '0;
    gains = '0;
    cyc(20);
    rst_n = 1'b1;
    // random steady points; first two are zero error and saturation
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      {ana2, ana1, target2, target1} = r;
      r = rnd();
      {ana4, ana3} = r[15:0];
      analog_cmd_mode = r[16];
      gains = '{kp: {4'h0, r[23:20]}, ki: 8'h00, kd: r[31:24]};
      if (i == 0) {target1, target2} = analog_cmd_mode ? {ana3, ana4} : {ana1, ana2};
      if (i == 1) {target1, ana1, ana3, gains.kp} = {8'sh7f, 8'sh81, 8'sh81, 8'h0f};
      if (target1 == 8'sh80) target1 = 8'sh81;
      if (target2 == 8'sh80) target2 = 8'sh81;
      cyc(3 * PER);
      e = int'(target1) - int'(analog_cmd_mode ? ana3 : ana1);
      chk("power1", power1, pexp(e, 0, gains.kp, gains.kd));
      e = int'(target2) - int'(analog_cmd_mode ? ana4 : ana2);
      chk("power2", power2, pexp(e, 0, gains.kp, gains.kd));
    end
    // step: the first period after it carries the error change
    {analog_cmd_mode, ana1, ana2, target1, target2} = {1'b0, 8'sh00, 8'sh00, 8'sh04, 8'sh28};
    gains = '{kp: 8'h08, ki: 8'h00, kd: 8'h10};
    cyc(3 * PER);
    target1 = 8'sh0c;
    wait_p1(8'sh04);
    chk("pd_step", power1, pexp(12, 8, 8, 16));
    cyc(2 * PER);
    chk("pd_settle", power1, 8'sh0c);
    // emergency stop removes both channels and holds them off
    estop = 1'b1;
    cyc(5);
    chk("estop_p1", power1, 8'sh00);
    chk("estop_p2", power2, 8'sh00);
    chk("estop_on", motors_on, 1'b0);
    gains = '{kp: 8'h00, ki: 8'h08, kd: 8'h00};
    target1 = 8'sh02;
    cyc(3 * PER);
    chk("estop_hold", {power1, power2}, 16'h0000);
    estop = 1'b0;
    cyc(5);
    chk("resume_on", motors_on, 1'b1);
    // integrator restarts from zero and grows by the error each period
    wait_p1(8'sh00);
    p = power1;
    wait_p1(p);
    chk("int_grow", power1, p + 8'sh02);
    // encoder watch: power just under a quarter never faults
    gains = '{kp: 8'h08, ki: 8'h00, kd: 8'h00};
    {target1, target2, encoder_en, stall} = {8'sh1f, 8'she1, 1'b1, 1'b1};
    cyc((NM + 4) * PER);
    chk("low_power", enc_fault, 1'b0);
    {target1, target2, stall} = {8'sh20, 8'she0, 1'b0};
    cyc(6 * PER);
    chk("moving", enc_fault, 1'b0);
    stall = 1'b1;
    for (k = 0; k < (NM + 4) * PER && enc_fault !== 1'b1; k++) cyc(1);
    chk("fault", enc_fault, 1'b1);
    chk("fault_span", k >= NM * PER, 1'b1);
    old = diag_led;
    for (k = 0; k < FL + 4 && diag_led === old; k++) cyc(1);
    chk("led_flash", diag_led, !old);
    stall = 1'b0;
    cyc(4 * PER);
    chk("halt_stays", {enc_fault, power1, power2}, 17'h10000);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    encoder_en = 1'b0;
    cyc(2);
    chk("reset_clears", {enc_fault, diag_led}, 2'b00);
    wrap_up();
  end
endmodule // ppid_top_tb_top
`default_nettype wire
